// ---- hdl/srgs_pkg.sv ----
// Package: timing defaults and state encoding for the gate sequencer
package srgs_pkg;
  localparam int unsigned ClkPeriodNs = 10;
  localparam int unsigned TimerWidth = 16;
  // Interval figures in ns (defaults; parts differ)
  localparam int unsigned MinOnNs = 1000;
  localparam int unsigned MinOffNs = 1000;
  localparam int unsigned BlankNs = 100;
  localparam int unsigned DisQualNs = 20000;
  localparam int unsigned DisEndNs = 10000;
  localparam int unsigned DisRecNs = 40000;
  // Least times round up, longest times round down
  localparam int unsigned MinOnCyc = (MinOnNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int unsigned MinOffCyc = (MinOffNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int unsigned BlankCyc = (BlankNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int unsigned DisQualCyc = (DisQualNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int unsigned DisEndCyc = (DisEndNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int unsigned DisRecCyc = DisRecNs / ClkPeriodNs;
  localparam int unsigned SyncStages = 3;

  typedef enum logic [5:0] {
    SRGS_ST_WAIT_REARM = 6'h01,
    SRGS_ST_MIN_OFF = 6'h02,
    SRGS_ST_ARMED = 6'h04,
    SRGS_ST_ON = 6'h08,
    SRGS_ST_DISABLED = 6'h10,
    SRGS_ST_RECOVER = 6'h20
  } srgs_state_t;
endpackage

// ---- hdl/srgs_sequencer.sv ----
// Synchronous-rectifier gate sequencer: drive on/off, disable and recovery control
// ==========================================
// Summary of operation
// - Trigger rising while driving releases drive at once, overriding minimum on-time.
// - Trigger low and minimum on-time elapsed: turn-off flag releases drive.
// - Early turn-off flag holds drive until minimum on-time ends, then releases.
// - After release, minimum off-time waits for sense above rearm level.
// - Drive turns on only if trigger is low when turn-on flag rises.
// - Trigger high beyond qualify time enters disable mode; drive held low.
// - Trigger low for exit time ends disable; recovery follows with drive low.
// - Once exit time met, recovery continues even if trigger returns high.
// - After recovery, full minimum off-time, then turn on at next falling edge.
// - Sense below rearm level aborts minimum off-time; restart from zero later.
// - After reset or wake-up, one uninterrupted minimum off-time precedes any drive.
// - At start-up or wake-up, off-timer starts at once if sense is high.
// - Trigger release is edge sensitive; short needle pulses still release drive.
// - Trigger ignored during blanking after turn-on; level reevaluated when blanking ends.
// - Outside blanking, high trigger releases drive or blocks turn-on.
`timescale 1ns/1ps
module srgs_sequencer #(
  parameter int unsigned MinOnCycles = srgs_pkg::MinOnCyc,
  parameter int unsigned MinOffCycles = srgs_pkg::MinOffCyc,
  parameter int unsigned BlankCycles = srgs_pkg::BlankCyc,
  parameter int unsigned DisQualCycles = srgs_pkg::DisQualCyc,
  parameter int unsigned DisEndCycles = srgs_pkg::DisEndCyc,
  parameter int unsigned DisRecCycles = srgs_pkg::DisRecCyc
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic triggerDisableInput,
  input wire logic senseTurnOnLevel,
  input wire logic senseTurnOffLevel,
  input wire logic senseRearmLevel,
  input wire logic lightLoadDetectPin,
  output logic gateDriveOutput,
  output logic disableMode
);
  localparam int unsigned W = srgs_pkg::TimerWidth;

  // ==========================================
  // Input synchronisers
  logic trigSync;
  logic onSync;
  logic offSync;
  logic rearmSync;
  logic lldSync;
  srgs_sync u_sync_trig (
    .clk(clk),
    .resetn(resetn),
    .async(triggerDisableInput),
    .synced(trigSync)
  );
  srgs_sync u_sync_on (
    .clk(clk),
    .resetn(resetn),
    .async(senseTurnOnLevel),
    .synced(onSync)
  );
  srgs_sync u_sync_off (
    .clk(clk),
    .resetn(resetn),
    .async(senseTurnOffLevel),
    .synced(offSync)
  );
  srgs_sync u_sync_rearm (
    .clk(clk),
    .resetn(resetn),
    .async(senseRearmLevel),
    .synced(rearmSync)
  );
  // Slow pin; three stages cost little next to a wake-up
  srgs_sync u_sync_lld (
    .clk(clk),
    .resetn(resetn),
    .async(lightLoadDetectPin),
    .synced(lldSync)
  );

  // ==========================================
  // State and edge registers
  srgs_pkg::srgs_state_t state_q;
  srgs_pkg::srgs_state_t state_d;
  logic onPrev_q;
  logic trigEdge_q;
  logic trigEdge_d;
  logic lldPrev_q;

  // Needle pulse capture: async-set latch of a trigger rising edge, cleared by the clock.
  // Catches pulses far shorter than a clock period.
  logic needleClr;
  // Reset clears it so a stale capture cannot block the first turn-on
  always_ff @(posedge triggerDisableInput or posedge needleClr or negedge resetn) begin
    if (!resetn) begin
      trigEdge_q <= 1'b0;
    end else if (needleClr) begin
      trigEdge_q <= 1'b0;
    end else begin
      trigEdge_q <= 1'b1;
    end
  end
  logic needleSeen_q;
  logic needleSeen2_q;
  assign needleClr = needleSeen2_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      needleSeen_q <= 1'b0;
      needleSeen2_q <= 1'b0;
    end else begin
      needleSeen_q <= trigEdge_q;
      needleSeen2_q <= needleSeen_q;
    end
  end
  assign trigEdge_d = needleSeen2_q;

  // ==========================================
  // Timers
  wire inOn = (state_q == srgs_pkg::SRGS_ST_ON);
  wire inOff = (state_q == srgs_pkg::SRGS_ST_MIN_OFF);
  wire inDis = (state_q == srgs_pkg::SRGS_ST_DISABLED);
  wire inRec = (state_q == srgs_pkg::SRGS_ST_RECOVER);
  wire minOnDone;
  wire minOffDone;
  wire blankDone;
  wire qualDone;
  wire endDone;
  wire recDone;

  // ==========================================
  // Functions
  // Terminal counts are cut to the timer width on purpose; larger values wrap
  function automatic logic [W-1:0] termOf(input int unsigned cycles);
    return W'(cycles);
  endfunction

  srgs_timer #(
    .Width(W)
  ) u_min_on (
    .clk(clk),
    .resetn(resetn),
    .run(inOn),
    .terminal(termOf(MinOnCycles)),
    .done(minOnDone)
  );
  // Run drops with the rearm level, so any dip restarts the count from zero
  srgs_timer #(
    .Width(W)
  ) u_min_off (
    .clk(clk),
    .resetn(resetn),
    .run(inOff && rearmSync),
    .terminal(termOf(MinOffCycles)),
    .done(minOffDone)
  );
  srgs_timer #(
    .Width(W)
  ) u_blank (
    .clk(clk),
    .resetn(resetn),
    .run(inOn),
    .terminal(termOf(BlankCycles)),
    .done(blankDone)
  );
  srgs_timer #(
    .Width(W)
  ) u_qual (
    .clk(clk),
    .resetn(resetn),
    .run(trigSync && !inDis && !inRec),
    .terminal(termOf(DisQualCycles)),
    .done(qualDone)
  );
  // Trigger must stay low without a break for the whole exit time
  srgs_timer #(
    .Width(W)
  ) u_end (
    .clk(clk),
    .resetn(resetn),
    .run(inDis && !trigSync),
    .terminal(termOf(DisEndCycles)),
    .done(endDone)
  );
  srgs_timer #(
    .Width(W)
  ) u_rec (
    .clk(clk),
    .resetn(resetn),
    .run(inRec),
    .terminal(termOf(DisRecCycles)),
    .done(recDone)
  );

  // ==========================================
  // Event decode
  wire onRise = onSync && !onPrev_q;
  wire lldWake = lldPrev_q && !lldSync;
  // A wake never cuts a drive pulse or a disable sequence short
  wire lldRestart = lldWake && !inDis && !inRec && !inOn;
  wire armedTurnOn = onRise && !trigSync && !trigEdge_d;
  // Blanking masks both the level and the captured edge; an edge caught in the last three blank cycles still acts once blanking ends
  wire trigActive = (trigSync || trigEdge_d) && blankDone;

  // ==========================================
  // Turn-off qualification
  // An early turn-off flag is remembered, so a flag that falls again before
  // the minimum on-time ends still releases the drive at its end
  logic offSeen_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      offSeen_q <= 1'b0;
    end else begin
      offSeen_q <= inOn && (offSeen_q || offSync);
    end
  end
  wire offRelease = (offSync || offSeen_q) && minOnDone;

  always_comb begin
    state_d = state_q;
    case (state_q)
      srgs_pkg::SRGS_ST_WAIT_REARM: begin
        if (qualDone) begin
          state_d = srgs_pkg::SRGS_ST_DISABLED;
        end else if (rearmSync) begin
          state_d = srgs_pkg::SRGS_ST_MIN_OFF;
        end
      end
      srgs_pkg::SRGS_ST_MIN_OFF: begin
        if (qualDone) begin
          state_d = srgs_pkg::SRGS_ST_DISABLED;
        end else if (!rearmSync) begin
          state_d = srgs_pkg::SRGS_ST_WAIT_REARM;
        end else if (minOffDone) begin
          state_d = srgs_pkg::SRGS_ST_ARMED;
        end
      end
      srgs_pkg::SRGS_ST_ARMED: begin
        if (qualDone) begin
          state_d = srgs_pkg::SRGS_ST_DISABLED;
        end else if (armedTurnOn) begin
          state_d = srgs_pkg::SRGS_ST_ON;
        end
      end
      srgs_pkg::SRGS_ST_ON: begin
        if (trigActive || offRelease) begin
          state_d = srgs_pkg::SRGS_ST_WAIT_REARM;
        end
      end
      srgs_pkg::SRGS_ST_DISABLED: begin
        if (endDone) begin
          state_d = srgs_pkg::SRGS_ST_RECOVER;
        end
      end
      srgs_pkg::SRGS_ST_RECOVER: begin
        if (recDone) begin
          state_d = srgs_pkg::SRGS_ST_WAIT_REARM;
        end
      end
      default: begin
        state_d = srgs_pkg::SRGS_ST_WAIT_REARM;
      end
    endcase
    // Light-load wake restarts the off-time qualification
    if (lldRestart) begin
      state_d = srgs_pkg::SRGS_ST_WAIT_REARM;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= srgs_pkg::SRGS_ST_WAIT_REARM;
    end else begin
      state_q <= state_d;
    end
  end

  // Starts high, but the synchroniser resets low, so a turn-on flag already up at reset release still shows as an edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      onPrev_q <= 1'b1;
    end else begin
      onPrev_q <= onSync;
    end
  end

  // Starts at the synchroniser's reset level, so only a real fall is a wake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lldPrev_q <= 1'b0;
    end else begin
      lldPrev_q <= lldSync;
    end
  end

  // ==========================================
  // Outputs
  // Raw trigger gates the drive directly for lowest latency; blanked right after turn-on.
  // The captured needle keeps the drive low until the state has left ON,
  // so a pulse narrower than a clock cannot let the drive come back
  wire trigRelease = triggerDisableInput || trigEdge_q || trigEdge_d;
  assign gateDriveOutput = inOn && !(trigRelease && blankDone);
  assign disableMode = inDis || inRec;
endmodule

// ---- hdl/srgs_sync.sv ----
// Three-stage synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
module srgs_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic async,
  output logic synced
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end
  assign synced = out_q;
endmodule

// ---- hdl/srgs_timer.sv ----
// Up-counter with synchronous clear and done flag at a terminal count
`timescale 1ns/1ps
module srgs_timer #(
  parameter int unsigned Width = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [Width-1:0] terminal,
  output logic done
);
  logic [Width-1:0] cnt_q;
  logic [Width-1:0] cnt_d;
  // Stop counting at terminal so done holds until run drops
  assign cnt_d = !run ? '0 : (done ? cnt_q : cnt_q + 1'b1);
  assign done = run && (cnt_q >= terminal);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ---- sim/srgs_primary_model.sv ----
// Primary-side trigger source: level hold and needle pulses
`timescale 1ns/1ps
module srgs_primary_model (
  input wire logic holdHigh,
  input wire logic needleReq,
  output logic trig
);
  logic needle = 1'b0;
  // Needle far narrower than a clock, so only an edge catcher can see it
  always @(posedge needleReq) begin
    #3 needle = 1'b1;
    #4 needle = 1'b0;
  end
  assign trig = holdHigh | needle;
endmodule

// ---- sim/srgs_sequencer_assertions.sv ----
// Checker: port properties of the gate sequencer
`timescale 1ns/1ps
module srgs_sequencer_assertions #(
  parameter int unsigned MinOffCycles = 10,
  parameter int unsigned DisQualCycles = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic triggerDisableInput,
  input wire logic senseRearmLevel,
  input wire logic gateDriveOutput,
  input wire logic disableMode
);
  // ====
  // Helpers; margins cover the input synchroniser lag
  int unsigned trigCnt_q;
  int unsigned rearmCnt_q;
  logic armOk_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trigCnt_q <= 0;
      rearmCnt_q <= 0;
      armOk_q <= 1'b0;
    end else begin
      trigCnt_q <= triggerDisableInput ? trigCnt_q + 1 : 0;
      rearmCnt_q <= (senseRearmLevel && !gateDriveOutput && !disableMode) ? rearmCnt_q + 1 : 0;
      if (gateDriveOutput || disableMode) armOk_q <= 1'b0;
      else if (rearmCnt_q >= MinOffCycles) armOk_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_DRV_LOW_DISABLED: assert property (disableMode |-> !gateDriveOutput)
    else $error("drive high while disabled");
  AST_DRV_LOW_AFTER_RESET: assert property ($rose(resetn) |-> !gateDriveOutput [*8])
    else $error("drive soon after reset");
  AST_TRIG_HIGH_RELEASE: assert property (triggerDisableInput [*8] |-> !gateDriveOutput)
    else $error("drive kept under high trigger");
  AST_BLANK_HOLD: assert property ($rose(gateDriveOutput) |=> gateDriveOutput [*2])
    else $error("drive dropped in blanking");
  AST_MIN_ON_HOLD: assert property ($rose(gateDriveOutput) && !triggerDisableInput ##1
    !triggerDisableInput [*7] |-> gateDriveOutput) else $error("drive released before minimum on");
  AST_DISABLE_ENTRY: assert property (trigCnt_q == DisQualCycles + 8 |-> disableMode)
    else $error("disable not entered");
  AST_EXIT_WAIT: assert property ($fell(triggerDisableInput) && disableMode |-> disableMode [*8])
    else $error("disable left too early");
  AST_POST_REC_LOW: assert property ($fell(disableMode) |-> !gateDriveOutput [*8])
    else $error("drive right after recovery");
  AST_ARM_FIRST: assert property ($rose(gateDriveOutput) |-> armOk_q)
    else $error("drive without full off time");
endmodule
bind srgs_sequencer srgs_sequencer_assertions #(
  .MinOffCycles(MinOffCycles),
  .DisQualCycles(DisQualCycles)
) chk_u (.clk(clk), .resetn(resetn), .triggerDisableInput(triggerDisableInput),
  .senseRearmLevel(senseRearmLevel), .gateDriveOutput(gateDriveOutput), .disableMode(disableMode));

// ---- sim/srgs_sequencer_bench.sv ----
// Self-checking bench for the gate sequencer
`timescale 1ns/1ps
module srgs_sequencer_bench;
  localparam int unsigned MinOn = 10;
  localparam int unsigned MinOff = 10;
  localparam int unsigned DisQual = 20;
  localparam int unsigned DisEnd = 12;
  localparam int unsigned DisRec = 20;
  logic clk, resetn, trig, onL, offL, rearm, llPin, hold, needleReq, gate, dis;
  int errors = 0;
  int n_checks = 0;
  srgs_primary_model model_u (.holdHigh(hold), .needleReq(needleReq), .trig(trig));
  srgs_sequencer #(.MinOnCycles(MinOn), .MinOffCycles(MinOff), .BlankCycles(3), .DisQualCycles(DisQual),
    .DisEndCycles(DisEnd), .DisRecCycles(DisRec)) dut_u (.clk(clk), .resetn(resetn),
    .triggerDisableInput(trig), .senseTurnOnLevel(onL), .senseTurnOffLevel(offL), .senseRearmLevel(rearm),
    .lightLoadDetectPin(llPin), .gateDriveOutput(gate), .disableMode(dis));
  // ====
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", s, e, g);
    end
  endtask
  // Polls on falling edges so the value read has settled
  task automatic waitFor(input string s, input bit useDis, input logic e, input int m);
    int i;
    i = 0;
    @(negedge clk);
    while ((useDis ? dis : gate) !== e && i < m) begin
      @(negedge clk);
      i++;
    end
    chk(s, useDis ? dis : gate, e);
  endtask
  task automatic arm();
    @(posedge clk);
    rearm <= 1'b1;
    cyc(MinOff + 8);
  endtask
  // Drain falls below the turn-on level; a refusal is judged after a full latency
  task automatic fireOn(input string s, input logic e);
    @(posedge clk);
    onL <= 1'b1;
    rearm <= 1'b0;
    if (e) waitFor(s, 0, 1'b1, 10);
    else begin
      cyc(12);
      waitFor(s, 0, 1'b0, 0);
    end
    @(posedge clk);
    onL <= 1'b0;
  endtask
  task automatic fireOff(input string s);
    @(posedge clk);
    offL <= 1'b1;
    waitFor(s, 0, 1'b0, 16);
    @(posedge clk);
    offL <= 1'b0;
  endtask
  // ====
  // Scenarios
  task automatic s_normal();
    cyc(MinOff + 8);
    fireOn("startup on", 1'b1);
    cyc(MinOn + 2);
    fireOff("off flag");
    arm();
    llPin <= 1'b0;
    cyc(2);
    fireOn("wake wait", 1'b0);
    llPin <= 1'b1;
  endtask
  task automatic s_minOn();
    arm();
    fireOn("on", 1'b1);
    offL <= 1'b1;
    cyc(5);
    waitFor("min on hold", 0, 1'b1, 0);
    waitFor("min on end", 0, 1'b0, 10);
    @(posedge clk);
    offL <= 1'b0;
  endtask
  task automatic s_trig();
    arm();
    fireOn("on", 1'b1);
    cyc(7);
    needleReq <= 1'b1;
    @(posedge clk);
    needleReq <= 1'b0;
    waitFor("needle off", 0, 1'b0, 0);
    cyc(2);
    waitFor("needle stays off", 0, 1'b0, 0);
    fireOn("no rearm", 1'b0);
  endtask
  task automatic s_block();
    @(posedge clk);
    rearm <= 1'b1;
    cyc(6);
    rearm <= 1'b0;
    cyc(3);
    rearm <= 1'b1;
    cyc(6);
    fireOn("ringing", 1'b0);
    arm();
    hold <= 1'b1;
    cyc(2);
    fireOn("trig high", 1'b0);
    hold <= 1'b0;
  endtask
  task automatic s_disable();
    @(posedge clk);
    hold <= 1'b1;
    cyc(DisQual + 10);
    waitFor("enter", 1, 1'b1, 0);
    @(posedge clk);
    hold <= 1'b0;
    cyc(DisEnd + 6);
    hold <= 1'b1;
    cyc(3);
    hold <= 1'b0;
    waitFor("still rec", 1, 1'b1, 0);
    waitFor("rec done", 1, 1'b0, DisRec + 10);
    @(posedge clk);
    rearm <= 1'b1;
    cyc(5);
    fireOn("post rec", 1'b0);
    arm();
    fireOn("rearmed on", 1'b1);
    fireOff("rearmed off");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    {onL, offL, hold, needleReq} = 4'h0;
    rearm = 1'b1;
    llPin = 1'b1;
    cyc(10);
    resetn <= 1'b1;
    s_normal();
    s_minOn();
    s_trig();
    s_block();
    s_disable();
    end_of_test();
  end
  // Whole run is a few hundred cycles
  initial begin
    cyc(3000);
    errors++;
    end_of_test();
  end
endmodule
